// ===== common/cbe_pkg.sv
// package: constants and types for the conditional branch evaluator
`default_nettype none
package cbe_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int SREG_W = 8;
  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int SREG_H_BIT = 5;
  localparam int SREG_T_BIT = 6;
  localparam int SREG_V_BIT = 3;
  localparam int SREG_N_BIT = 2;
  // ----------------------------------------------------------------
  // reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam int CYC_NOT_TAKEN = 1;
  localparam int CYC_TAKEN = 2;
  // ----------------------------------------------------------------
  // branch selectors
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CBE_OP_NONE = 3'h0,
    CBE_OP_SIGNED_GE = 3'h1,
    CBE_OP_SIGNED_LT = 3'h2,
    CBE_OP_HALF_SET = 3'h3,
    CBE_OP_HALF_CLEAR = 3'h4,
    CBE_OP_XFER_SET = 3'h5,
    CBE_OP_XFER_CLEAR = 3'h6
  } cbe_op_type;
  typedef enum logic [0:0] {
    CBE_ST_IDLE = 1'b0,
    CBE_ST_TAKEN = 1'b1
  } cbe_state_type;
endpackage
`default_nettype wire

// ===== rtl/cbe_cond.sv
// condition evaluator for the branch selectors
`timescale 1ns/100ps
`default_nettype none
module cbe_cond
(
  // selector and flags
  input wire logic [2:0] op_i,
  input wire logic [7:0] sreg_i,
  // result
  output logic valid_o,
  output logic take_o
);
  wire logic flag_n;
  wire logic flag_v;
  wire logic flag_h;
  wire logic flag_t;
  wire logic sign_lt;
  assign flag_n = sreg_i[cbe_pkg::SREG_N_BIT];
  assign flag_v = sreg_i[cbe_pkg::SREG_V_BIT];
  assign flag_h = sreg_i[cbe_pkg::SREG_H_BIT];
  assign flag_t = sreg_i[cbe_pkg::SREG_T_BIT];
  assign sign_lt = flag_n ^ flag_v;
  assign valid_o = (op_i != 3'h0) && (op_i <= 3'h6);
  assign take_o =
    (op_i == 3'h1) ? ~sign_lt :   // [RL1]
    (op_i == 3'h2) ? sign_lt :    // [RL2]
    (op_i == 3'h3) ? flag_h :     // [RL3]
    (op_i == 3'h4) ? ~flag_h :    // [RL4]
    (op_i == 3'h5) ? flag_t :     // [RL5]
    (op_i == 3'h6) ? ~flag_t :    // [RL6]
    1'b0;
endmodule // cbe_cond
`default_nettype wire

// ===== rtl/cbe_branch_eval.sv
// conditional relative branch evaluator
// Behaviour
// RL1 - signed ge jumps to pc+k+1 when n xor v is 0, no flag change, 1/2 cy.
// RL2 - signed lt jumps to pc+k+1 when n xor v is 1, no flag change, 1/2 cy.
// RL3 - half-carry set jumps to pc+k+1 when h is 1, else falls through.
// RL4 - half-carry clear jumps to pc+k+1 when h is 0, else falls through.
// RL5 - transfer set jumps to pc+k+1 when t is 1, else falls through.
// RL6 - transfer clear jumps to pc+k+1 when t is 0, else falls through.
// RL7 - k is a signed word offset; one cycle not taken, two cycles taken.
`timescale 1ns/100ps
`default_nettype none
module cbe_branch_eval
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // instruction issue
  input wire logic issue_i,
  input wire logic [2:0] op_i,
  input wire logic [6:0] ofs_i,
  input wire logic [15:0] pc_i,
  // status register
  input wire logic [7:0] sreg_i,
  // results
  output logic busy_o,
  output logic done_o,
  output logic taken_o,
  output logic pc_load_o,
  output logic [15:0] pc_next_o,
  output logic [7:0] sreg_o
);
  // ----------------------------------------------------------------
  // condition and target
  // ----------------------------------------------------------------
  wire logic cond_valid;
  wire logic cond_take;
  wire logic [15:0] ofs_ext;
  wire logic [15:0] pc_seq;
  wire logic [15:0] pc_target;
  wire logic accept;
  cbe_cond u_cond
  (
    .op_i(op_i),
    .sreg_i(sreg_i),
    .valid_o(cond_valid),
    .take_o(cond_take)
  );
  assign ofs_ext = {{9{ofs_i[6]}}, ofs_i};  // [RL7]
  assign pc_seq = pc_i + cbe_pkg::PC_STEP;
  assign pc_target = pc_seq + ofs_ext;  // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6]
  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  cbe_pkg::cbe_state_type state_reg;
  cbe_pkg::cbe_state_type state_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  logic taken_reg;
  logic taken_next;
  logic load_reg;
  logic load_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] target_reg;
  logic [15:0] target_next;
  logic [7:0] sreg_reg;
  logic [7:0] sreg_next;
  wire logic in_taken;
  wire logic finish_short;
  assign accept = issue_i && cond_valid && (state_reg == cbe_pkg::CBE_ST_IDLE);
  assign in_taken = (state_reg == cbe_pkg::CBE_ST_TAKEN);
  assign finish_short = accept && !cond_take;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      cbe_pkg::CBE_ST_IDLE:
      begin
        if (accept && cond_take)
          state_next = cbe_pkg::CBE_ST_TAKEN;  // [RL7]
      end
      cbe_pkg::CBE_ST_TAKEN:
      begin
        state_next = cbe_pkg::CBE_ST_IDLE;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  assign busy_next = (state_next == cbe_pkg::CBE_ST_TAKEN);
  // not taken: done at once; taken: done after second cycle [RL7]
  assign done_next = finish_short || in_taken;
  assign taken_next = in_taken;
  assign load_next = in_taken;
  assign target_next = accept ? (cond_take ? pc_target : pc_seq)
                              : target_reg;
  // flags pass through untouched [RL1] [RL2] [RL3] [RL4] [RL5] [RL6]
  assign sreg_next = accept ? sreg_i : sreg_reg;
  assign pc_next = finish_short ? pc_seq :
                   in_taken ? target_reg :
                   pc_reg;
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= cbe_pkg::CBE_ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end
  // ----------------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      busy_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
    end
  end
  // ----------------------------------------------------------------
  // done pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= done_next;
    end
  end
  // ----------------------------------------------------------------
  // taken pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      taken_reg <= 1'b0;
    end
    else
    begin
      taken_reg <= taken_next;
    end
  end
  // ----------------------------------------------------------------
  // pc load pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      load_reg <= 1'b0;
    end
    else
    begin
      load_reg <= load_next;
    end
  end
  // ----------------------------------------------------------------
  // jump target held over the second cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      target_reg <= cbe_pkg::PC_RESET;
    end
    else
    begin
      target_reg <= target_next;
    end
  end
  // ----------------------------------------------------------------
  // flag copy
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      sreg_reg <= cbe_pkg::SREG_RESET;
    end
    else
    begin
      sreg_reg <= sreg_next;
    end
  end
  // ----------------------------------------------------------------
  // next program counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      pc_reg <= cbe_pkg::PC_RESET;
    end
    else
    begin
      pc_reg <= pc_next;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign taken_o = taken_reg;
  assign pc_load_o = load_reg;
  assign pc_next_o = pc_reg;
  assign sreg_o = sreg_reg;
endmodule // cbe_branch_eval
`default_nettype wire

// ===== sim/cbe_branch_eval_sva.sv
// assertions for the conditional branch evaluator
`timescale 1ns/100ps
`default_nettype none
module cbe_branch_eval_sva
(
  // clock, reset and issue
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic issue_i,
  input wire logic [2:0] op_i,
  input wire logic [6:0] ofs_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] sreg_i,
  // results
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic taken_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_next_o,
  input wire logic [7:0] sreg_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic nv = sreg_i[2] ^ sreg_i[3];
  wire logic go = issue_i && !busy_o;
  wire logic [15:0] tgt = pc_i + {{9{ofs_i[6]}}, ofs_i} + 16'h0001;
  property p_ge; go && op_i == 3'h1 && !nv |-> ##2 pc_load_o &&
    pc_next_o == $past(tgt, 2); endproperty
  a_ge: assert property (p_ge) else $error("ge target wrong");
  property p_lt; go && op_i == 3'h2 && nv |=> busy_o ##1 done_o &&
    taken_o; endproperty
  a_lt: assert property (p_lt) else $error("lt not taken");
  property p_hs; go && op_i == 3'h3 && !sreg_i[5] |=> done_o &&
    !taken_o && pc_next_o == $past(pc_i) + 16'h0001; endproperty
  a_hs: assert property (p_hs) else $error("hs fall wrong");
  property p_hc; go && op_i == 3'h4 && sreg_i[5] |=> done_o &&
    !busy_o; endproperty
  a_hc: assert property (p_hc) else $error("hc fall wrong");
  property p_ts; go && op_i == 3'h5 && sreg_i[6] |-> ##2 taken_o &&
    $past(busy_o); endproperty
  a_ts: assert property (p_ts) else $error("ts not taken");
  property p_tc; go && op_i == 3'h6 |=> sreg_o == $past(sreg_i);
  endproperty
  a_tc: assert property (p_tc) else $error("flags changed");
  property p_cyc; busy_o |=> done_o && pc_load_o && !busy_o; endproperty
  a_cyc: assert property (p_cyc) else $error("taken cycles");
endmodule // cbe_branch_eval_sva
bind cbe_branch_eval cbe_branch_eval_sva u_sva (.*);
`default_nettype wire

// ===== sim/cbe_branch_eval_tb.sv
// testbench for the conditional branch evaluator
`timescale 1ns/100ps
`default_nettype none
module cbe_branch_eval_tb;
  logic clk, busy, done, tkn, ld;
  logic rstn = 1'b0;
  logic iss = 1'b0;
  logic [2:0] op = 3'h0;
  logic [6:0] k = 7'h00;
  logic [15:0] pc = 16'hfff0;
  logic [15:0] pcn;
  logic [7:0] sr = 8'h00;
  logic [7:0] sro;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  cbe_branch_eval uut (.sys_clk_i(clk), .resetn_i(rstn), .issue_i(iss),
    .op_i(op), .ofs_i(k), .pc_i(pc), .sreg_i(sr), .busy_o(busy),
    .done_o(done), .taken_o(tkn), .pc_load_o(ld), .pc_next_o(pcn),
    .sreg_o(sro));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one branch, judged at done
  task automatic br(logic [2:0] o, logic [7:0] f, logic [6:0] d, logic t);
    logic [15:0] e;
    e = pc + {{9{d[6]}}, d} + 16'h0001;
    op = o;
    sr = f;
    k = d;
    iss = 1'b1;
    @(posedge clk) #1;
    iss = 1'b0;
    if (t)
    begin
      chk("busy", {15'h0, busy}, 16'h0001);
      @(posedge clk) #1;
    end
    chk("done", {12'h0, done, tkn, ld, busy}, {12'h0, 1'b1, t, t, 1'b0});
    chk("pc", pcn, t ? e : pc + 16'h0001);
    chk("sreg", {8'h0, sro}, {8'h0, f});
    pc = pc + 16'h0101;
    @(posedge clk) #1;
    chk("pulse", {13'h0, done, tkn, ld}, 16'h0000);
  endtask
  task automatic t_signed();
    br(3'h1, 8'h00, 7'h3f, 1'b1);
    br(3'h1, 8'h04, 7'h01, 1'b0);
    br(3'h2, 8'h08, 7'h40, 1'b1);
    br(3'h2, 8'h0c, 7'h05, 1'b0);
  endtask
  task automatic t_flags();
    br(3'h3, 8'h20, 7'h7f, 1'b1);
    br(3'h3, 8'hdf, 7'h10, 1'b0);
    br(3'h4, 8'h00, 7'h41, 1'b1);
    br(3'h4, 8'h20, 7'h02, 1'b0);
    br(3'h5, 8'h40, 7'h00, 1'b1);
    br(3'h5, 8'hbf, 7'h03, 1'b0);
    br(3'h6, 8'h00, 7'h7e, 1'b1);
    br(3'h6, 8'h40, 7'h04, 1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_signed();
    t_flags();
    end_sim();
  end
endmodule // cbe_branch_eval_tb
`default_nettype wire
